/* File: spwm_core.sv */
`timescale 1ns/10ps
// How it works
// (RULE_01) time base is counter plus two low bits
// (RULE_02) at 1:1 low bits are clock phase
// (RULE_03) period is (limit+1)*4*clock*prescale
// (RULE_04) after limit match: clear, set pin, reload; here the pin is set only when duty_next is nonzero
// (RULE_05) duty upper eight bits plus control bits 5:4
// (RULE_06) duty writes anytime, take effect next period
// (RULE_07) shadow read-only while pwm mode active
// (RULE_08) shadow and hidden latch double buffer duty
// (RULE_09) pin clears when time base equals duty
// (RULE_10) duty beyond period leaves pin unchanged
// (RULE_11) postscaler plays no part in pwm
// (RULE_12) prescale ratios one, four and sixteen
// (RULE_13) resolution is log2 of 4*(limit+1)
// (RULE_14) flag sets when counter reaches limit
// (RULE_15) software setup order with optional flag wait
// (RULE_16) sleep freezes everything, pin holds level
// (RULE_17) all timing derived from system clock
// (RULE_18) zero control register releases the pin
// (RULE_19) reset makes pin input, registers reset
// (RULE_20) only pwm mode code enables pwm logic
module spwm_core (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic sleep_i,
  input wire logic ctrl_we_i,
  input wire logic [spwm_pkg::CTRL_W-1:0] ctrl_wdata_i,
  input wire logic limit_we_i,
  input wire logic [spwm_pkg::PERIOD_W-1:0] limit_wdata_i,
  input wire logic duty_we_i,
  input wire logic [spwm_pkg::PERIOD_W-1:0] duty_wdata_i,
  input wire logic shadow_we_i,
  input wire logic [spwm_pkg::PERIOD_W-1:0] shadow_wdata_i,
  input wire logic tb_ctrl_we_i,
  input wire logic tb_run_i,
  input wire logic [spwm_pkg::PSEL_W-1:0] tb_psel_i,
  input wire logic flag_clr_i,
  input wire logic pin_dir_we_i,
  input wire logic pin_dir_i,
  output logic [spwm_pkg::CTRL_W-1:0] module_control_o,
  output logic [spwm_pkg::PERIOD_W-1:0] period_limit_o,
  output logic [spwm_pkg::PERIOD_W-1:0] duty_upper_bits_o,
  output logic [spwm_pkg::PERIOD_W-1:0] duty_shadow_o,
  output logic [spwm_pkg::PERIOD_W-1:0] period_counter_o,
  output logic timebase_run_o,
  output logic [spwm_pkg::PSEL_W-1:0] timebase_prescale_select_o,
  output logic period_match_flag_o,
  output logic pin_direction_o,
  output logic pwm_output_pin_o,
  output logic pwm_output_pin_oe_o
);
  import spwm_pkg::*;

  logic [CTRL_W-1:0] ctrl_r;
  logic [PERIOD_W-1:0] limit_r;
  logic [PERIOD_W-1:0] duty_r;
  logic [PERIOD_W-1:0] shadow_r;
  logic [EXT_W-1:0] latch_r;
  logic [PERIOD_W-1:0] count_r;
  logic run_r;
  logic [PSEL_W-1:0] psel_r;
  logic flag_r;
  logic dir_r;
  logic pin_r;
  logic oe_r;
  logic [EXT_W-1:0] ext;
  logic tick;
  logic active;
  logic awake;
  logic step;
  logic wrap;
  logic [DUTY_W-1:0] timebase;
  logic [DUTY_W-1:0] duty_active;
  logic [DUTY_W-1:0] duty_next;

  function automatic logic is_pwm(input logic [CTRL_W-1:0] c);
    is_pwm = ((c[CTRL_MODE_HI:CTRL_MODE_LO] & MODE_PWM_MASK) == MODE_PWM);
  endfunction : is_pwm

  assign awake = !sleep_i; // RULE_16
  assign active = is_pwm(ctrl_r); // RULE_20
  assign step = awake && run_r && tick; // RULE_17
  assign wrap = step && (ext == 2'h3);
  assign timebase = {count_r, ext}; // RULE_01
  assign duty_active = {shadow_r, latch_r}; // RULE_08
  assign duty_next = {duty_r, ctrl_r[CTRL_DLSB_HI:CTRL_DLSB_LO]}; // RULE_05

  // prescaler only; no postscaler in this path
  spwm_prescale u_pre ( // RULE_11
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .run_i(awake && run_r),
    .psel_i(psel_r),
    .ext_o(ext),
    .tick_o(tick)
  );

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl_r <= CTRL_RST; // RULE_19
      duty_r <= DUTY_RST;
      limit_r <= LIMIT_RST;
    end else if (awake) begin
      if (ctrl_we_i) begin
        ctrl_r <= ctrl_wdata_i; // RULE_06
      end
      if (duty_we_i) begin
        duty_r <= duty_wdata_i;
      end
      if (limit_we_i) begin
        limit_r <= limit_wdata_i;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      run_r <= 1'b0;
      psel_r <= PSEL_RST;
      dir_r <= 1'b1;
    end else if (awake) begin
      if (tb_ctrl_we_i) begin
        run_r <= tb_run_i;
        psel_r <= (tb_psel_i == 2'h3) ? PSEL_DIV16 : tb_psel_i; // RULE_12
      end
      if (pin_dir_we_i) begin
        dir_r <= pin_dir_i; // RULE_15
      end
    end
  end

  // period counter: (limit+1) counts of four quarter steps
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      count_r <= COUNT_RST;
    end else if (wrap) begin
      if (count_r == limit_r) begin
        count_r <= COUNT_RST; // RULE_04
      end else begin
        count_r <= count_r + 8'h01; // RULE_03
      end
    end
  end

  // shadow reload at period end, protected in pwm mode
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      shadow_r <= DUTY_RST;
      latch_r <= '0;
    end else if (awake) begin
      if (wrap && (count_r == limit_r)) begin
        shadow_r <= duty_next[DUTY_W-1:EXT_W]; // RULE_06
        latch_r <= duty_next[EXT_W-1:0];
      end else if (shadow_we_i && !active) begin
        shadow_r <= shadow_wdata_i; // RULE_07
      end
    end
  end

  // flag: set wins over clear
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      flag_r <= 1'b0;
    end else if (wrap && (count_r == limit_r)) begin
      flag_r <= 1'b1; // RULE_14
    end else if (flag_clr_i && awake) begin
      flag_r <= 1'b0;
    end
  end

  // output level: set at period start unless the duty is zero, clear on duty match
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pin_r <= 1'b0;
    end else if (!active) begin
      pin_r <= 1'b0;
    end else if (wrap && (count_r == limit_r)) begin
      pin_r <= (duty_next != '0); // RULE_04
    end else if (step && (timebase + 10'h001 == duty_active)) begin
      pin_r <= 1'b0; // RULE_09
    end
  end
  // a duty above 4*(limit+1)-1 is never matched, so the pin stays set (RULE_10, RULE_13)

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      oe_r <= 1'b0; // RULE_19
    end else if (awake) begin
      oe_r <= active && !dir_r && (ctrl_r != '0); // RULE_18
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      module_control_o <= CTRL_RST;
      period_limit_o <= LIMIT_RST;
      duty_upper_bits_o <= DUTY_RST;
      duty_shadow_o <= DUTY_RST;
      period_counter_o <= COUNT_RST;
      timebase_run_o <= 1'b0;
      timebase_prescale_select_o <= PSEL_RST;
      period_match_flag_o <= 1'b0;
      pin_direction_o <= 1'b1;
    end else begin
      module_control_o <= ctrl_r;
      period_limit_o <= limit_r;
      duty_upper_bits_o <= duty_r;
      duty_shadow_o <= shadow_r;
      period_counter_o <= count_r;
      timebase_run_o <= run_r;
      timebase_prescale_select_o <= psel_r;
      period_match_flag_o <= flag_r;
      pin_direction_o <= dir_r;
    end
  end

  assign pwm_output_pin_o = pin_r;
  assign pwm_output_pin_oe_o = oe_r;
endmodule : spwm_core

/* File: spwm_pkg.sv */
package spwm_pkg;
  localparam int PERIOD_W = 8;
  localparam int DUTY_W = 10;
  localparam int EXT_W = 2;
  localparam int MODE_W = 4;
  localparam int CTRL_W = 8;
  localparam int PSEL_W = 2;
  localparam logic [PSEL_W-1:0] PSEL_DIV1 = 2'h0;
  localparam logic [PSEL_W-1:0] PSEL_DIV4 = 2'h1;
  localparam logic [PSEL_W-1:0] PSEL_DIV16 = 2'h2;
  localparam int CTRL_DLSB_HI = 5;
  localparam int CTRL_DLSB_LO = 4;
  localparam int CTRL_MODE_HI = 3;
  localparam int CTRL_MODE_LO = 0;
  localparam logic [MODE_W-1:0] MODE_PWM = 4'hC;
  localparam logic [MODE_W-1:0] MODE_PWM_MASK = 4'hC;
  localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;
  localparam logic [PERIOD_W-1:0] LIMIT_RST = 8'hFF;
  localparam logic [PERIOD_W-1:0] DUTY_RST = 8'h00;
  localparam logic [PERIOD_W-1:0] COUNT_RST = 8'h00;
  localparam logic [PSEL_W-1:0] PSEL_RST = 2'h0;
  localparam int PHASE_COUNT = 4;
  localparam int PRE_W = 4;
endpackage : spwm_pkg

/* File: spwm_prescale.sv */
`timescale 1ns/10ps
module spwm_prescale (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic run_i,
  input wire logic [spwm_pkg::PSEL_W-1:0] psel_i,
  output logic [spwm_pkg::EXT_W-1:0] ext_o,
  output logic tick_o
);
  import spwm_pkg::*;
  logic [PRE_W-1:0] pre_r;
  logic [PRE_W-1:0] pre_nxt;
  logic [EXT_W-1:0] phase_r;

  // divider: 1, 4 or 16 clocks per quarter step
  always_comb begin
    pre_nxt = pre_r + 4'h1;
    case (psel_i)
      PSEL_DIV1: tick_o = 1'b1;
      PSEL_DIV4: tick_o = (pre_r[1:0] == 2'h3);
      default: tick_o = (pre_r == 4'hF); // RULE_12
    endcase
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pre_r <= '0;
    end else if (run_i) begin
      pre_r <= pre_nxt;
    end
  end

  // clock phase counter used at 1:1
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      phase_r <= '0;
    end else if (run_i && tick_o) begin
      phase_r <= phase_r + 2'h1;
    end
  end

  // extension bits: tick phase counter at every ratio, not prescaler bits
  always_comb begin
    case (psel_i)
      PSEL_DIV1: ext_o = phase_r; // RULE_02
      PSEL_DIV4: ext_o = phase_r;
      default: ext_o = phase_r; // RULE_01
    endcase
  end
endmodule : spwm_prescale

/* File: spwm_core_checker.sv */
`timescale 1ns/10ps
module spwm_core_checker (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic sleep_i,
  input wire logic [spwm_pkg::CTRL_W-1:0] module_control_o,
  input wire logic [spwm_pkg::PERIOD_W-1:0] period_limit_o,
  input wire logic [spwm_pkg::PERIOD_W-1:0] duty_shadow_o,
  input wire logic [spwm_pkg::PERIOD_W-1:0] period_counter_o,
  input wire logic period_match_flag_o,
  input wire logic pin_direction_o,
  input wire logic pwm_output_pin_o,
  input wire logic pwm_output_pin_oe_o
);
  import spwm_pkg::*;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_wrap; $rose(period_match_flag_o); endsequence
  sequence s_off; (module_control_o == CTRL_RST) [*2]; endsequence
  a_flag_at_wrap: assert property (s_wrap |-> period_counter_o == COUNT_RST)
    else $error("flag rose away from counter wrap");
  a_pin_set_wrap: assert property ($rose(pwm_output_pin_o) |-> ##[0:1] period_counter_o == COUNT_RST)
    else $error("pin rose away from counter wrap");
  a_count_step: assert property ($changed(period_counter_o)
    |-> period_counter_o == $past(period_counter_o) + 8'h01 || period_counter_o == COUNT_RST)
    else $error("counter moved by other than one step or wrap");
  a_shadow_reload: assert property ($changed(duty_shadow_o) && module_control_o[3:2] == 2'h3
    && $past(module_control_o[3:2]) == 2'h3 |-> period_counter_o == COUNT_RST)
    else $error("shadow changed mid period in pwm mode");
  a_sleep_freeze: assert property (sleep_i [*3] |-> $stable(period_counter_o) && $stable(pwm_output_pin_o))
    else $error("state moved during sleep");
  a_reset_vals: assert property ($rose(reset_n_i) |-> period_limit_o == LIMIT_RST && pin_direction_o
    && !pwm_output_pin_oe_o && period_counter_o == COUNT_RST)
    else $error("bad values after reset");
  a_ctrl_zero_off: assert property (s_off |-> !pwm_output_pin_oe_o)
    else $error("pin driven with control cleared");
  a_dir_gates_oe: assert property (pin_direction_o [*2] |-> !pwm_output_pin_oe_o)
    else $error("pin driven while direction is input");
  a_mode_gate: assert property ((module_control_o[3:2] != 2'h3) [*2] |-> !pwm_output_pin_o && !pwm_output_pin_oe_o)
    else $error("pwm active outside pwm mode");
endmodule : spwm_core_checker
bind spwm_core spwm_core_checker spwm_core_checker_inst (.mclk_i, .reset_n_i, .sleep_i, .module_control_o,
  .period_limit_o, .duty_shadow_o, .period_counter_o, .period_match_flag_o, .pin_direction_o,
  .pwm_output_pin_o, .pwm_output_pin_oe_o);

/* File: spwm_load.sv */
`timescale 1ns/10ps
module spwm_load (
  input wire logic mclk_i,
  input wire logic pin_i,
  input wire logic oe_i,
  output logic line_o,
  output int rises_o = 0,
  output int period_o = 0,
  output int high_o = 0
);
  int cnt = 0;
  int hcnt = 0;
  logic prev = 1'b0;
  // pull-down holds the load off while the pin is released
  assign line_o = oe_i ? pin_i : 1'b0;
  always @(posedge mclk_i) begin
    prev <= line_o;
    if (line_o && !prev) begin
      rises_o <= rises_o + 1;
      period_o <= cnt;
      high_o <= hcnt;
      cnt <= 1;
      hcnt <= 1;
    end else begin
      cnt <= cnt + 1;
      hcnt <= hcnt + int'(line_o);
    end
  end
endmodule : spwm_load

/* File: standard_pwm_ccp_bench.sv */
`timescale 1ns/10ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module standard_pwm_ccp_bench;
  logic mclk_i = 0, reset_n_i = 0, sleep_i = 0, ctrl_we_i = 0, limit_we_i = 0, duty_we_i = 0;
  logic shadow_we_i = 0, tb_ctrl_we_i = 0, tb_run_i = 0, flag_clr_i = 0, pin_dir_we_i = 0, pin_dir_i = 1;
  logic [7:0] ctrl_wdata_i = '0, limit_wdata_i = '0, duty_wdata_i = '0, shadow_wdata_i = '0;
  logic [7:0] module_control_o, period_limit_o, duty_upper_bits_o, duty_shadow_o, period_counter_o;
  logic [1:0] tb_psel_i = '0, timebase_prescale_select_o;
  logic timebase_run_o, period_match_flag_o, pin_direction_o, pwm_output_pin_o, pwm_output_pin_oe_o, line;
  int mismatches = 0, tests_run = 0, cycles = 0, seed = 97745, lim = 3, d, c, r0, rises, per_m, high_m;
  int pres[$] = '{1, 4, 16};
  spwm_core spwm_core_inst (.*);
  spwm_load spwm_load_inst (.mclk_i, .pin_i(pwm_output_pin_o), .oe_i(pwm_output_pin_oe_o), .line_o(line),
    .rises_o(rises), .period_o(per_m), .high_o(high_m));
  initial forever #2 mclk_i = ~mclk_i;
  task automatic tally_and_finish();
    if (mismatches == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles > 90000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  task automatic pulse(ref logic s);
    @(negedge mclk_i) s = 1;
    @(negedge mclk_i) s = 0;
  endtask : pulse
  task automatic setup(input int ps);
    pin_dir_i = 1;
    pulse(pin_dir_we_i);
    limit_wdata_i = 8'(lim);
    pulse(limit_we_i);
    ctrl_wdata_i = {2'h0, 2'(d), 4'hC};
    pulse(ctrl_we_i);
    duty_wdata_i = 8'(d >> 2);
    pulse(duty_we_i);
    pulse(flag_clr_i);
    tb_psel_i = 2'(ps);
    tb_run_i = 1;
    pulse(tb_ctrl_we_i);
    while (period_match_flag_o !== 1'b1) @(negedge mclk_i);
    pin_dir_i = 0;
    pulse(pin_dir_we_i);
  endtask : setup
  task automatic quiet(input logic lvl);
    repeat (8 * (lim + 1)) @(negedge mclk_i);
    r0 = rises;
    repeat (8 * (lim + 1)) @(negedge mclk_i);
    `CHK(rises, r0)
    `CHK(line, lvl)
  endtask : quiet
  initial begin
    repeat (16) @(posedge mclk_i);
    @(negedge mclk_i) reset_n_i = 1;
    @(negedge mclk_i);
    `CHK(period_limit_o, 8'hFF)
    `CHK(pin_direction_o, 1'b1)
    `CHK(pwm_output_pin_oe_o, 1'b0)
    shadow_wdata_i = 8'h5A;
    pulse(shadow_we_i);
    @(negedge mclk_i);
    `CHK(duty_shadow_o, 8'h5A)
    // two runs per ratio; the last one uses select code 3, which must act as 1:16
    for (int k = 0; k < 6; k++) begin
      lim = 3 + $unsigned($random(seed)) % 13;
      d = 1 + $unsigned($random(seed)) % (4 * lim + 3);
      setup((k == 5) ? 3 : k / 2);
      r0 = rises;
      while (rises < r0 + 3) @(negedge mclk_i);
      `CHK(per_m, (lim + 1) * 4 * pres[k / 2])
      `CHK(high_m, d * pres[k / 2])
      `CHK(timebase_prescale_select_o, 2'(k / 2))
      `CHK(duty_upper_bits_o, 8'(d >> 2))
      `CHK(timebase_run_o, 1'b1)
      shadow_wdata_i = 8'hA5;
      pulse(shadow_we_i);
      @(negedge mclk_i);
      `CHK(duty_shadow_o, 8'(d >> 2))
    end
    d = 0;
    setup(0);
    quiet(1'b0);
    d = 10'h3FF;
    setup(0);
    quiet(1'b1);
    sleep_i = 1;
    repeat (3) @(negedge mclk_i);
    c = period_counter_o;
    limit_wdata_i = 8'h00;
    pulse(limit_we_i);
    repeat (20) @(negedge mclk_i);
    `CHK(period_counter_o, 8'(c))
    `CHK(period_limit_o, 8'(lim))
    sleep_i = 0;
    for (int m = 0; m < 16; m++) begin
      ctrl_wdata_i = 8'(m);
      pulse(ctrl_we_i);
      repeat (2) @(negedge mclk_i);
      `CHK(pwm_output_pin_oe_o, 1'(m >= 12))
    end
    ctrl_wdata_i = 8'h00;
    pulse(ctrl_we_i);
    repeat (2) @(negedge mclk_i);
    `CHK(pwm_output_pin_oe_o, 1'b0)
    tally_and_finish();
  end
endmodule : standard_pwm_ccp_bench
